// ### hdl/psc_defines.svh
// Offsets, field positions, limits and timing counts of the serial config block.
`ifndef PSC_DEFINES_SVH
`define PSC_DEFINES_SVH
`define PSC_NUM_LATCH 6
`define PSC_SEL_R0 3'h0
`define PSC_SEL_LAST 3'h5
`define PSC_INT_HI 30
`define PSC_INT_LO 15
`define PSC_FRAC_HI 14
`define PSC_FRAC_LO 3
`define PSC_PRESC_BIT 27
`define PSC_PHASE_HI 26
`define PSC_PHASE_LO 15
`define PSC_NOISE_HI 30
`define PSC_NOISE_LO 29
`define PSC_MON_HI 28
`define PSC_MON_LO 26
`define PSC_DBL_BIT 25
`define PSC_RDIV2_BIT 24
`define PSC_RCNT_HI 23
`define PSC_RCNT_LO 14
`define PSC_CP_HI 12
`define PSC_CP_LO 9
`define PSC_LDF_BIT 8
`define PSC_TRI_BIT 4
`define PSC_ABP_BIT 22
`define PSC_INT_MIN_45 16'h0017
`define PSC_INT_MAX_45 16'h7FFF
`define PSC_INT_MIN_89 16'h004B
`define PSC_MOD_MIN_LN 12'h002
`define PSC_MOD_MIN_LS 12'h032
`define PSC_LOW_SPUR 2'h3
`define PSC_ABP_LONG_NS 6
`define PSC_ABP_SHORT_NS 3
`define PSC_CLK_NS 5
`define PSC_ABP_LONG_CYC ((`PSC_ABP_LONG_NS + `PSC_CLK_NS - 1) / `PSC_CLK_NS)
`define PSC_ABP_SHORT_CYC ((`PSC_ABP_SHORT_NS + `PSC_CLK_NS - 1) / `PSC_CLK_NS)
`define PSC_A_ACT1 8'h18
`define PSC_A_ACT2 8'h1C
`define PSC_A_STAT 8'h20
`define PSC_A_CTRL 8'h24
`define PSC_CTRL_RST 32'h00000001
`define PSC_RESP_OK 2'h0
`define PSC_RESP_ERR 2'h2
`endif

// ### hdl/psc_pkg.sv
// Types shared by the serial config block.
package psc_pkg;
  typedef struct packed {
    logic sclk;
    logic sdata;
    logic strobe;
  } psc_serial_t;
  typedef enum logic [1:0] {PSC_WIDLE, PSC_WRESP} psc_wstate_t;
endpackage

// ### hdl/psc_config_latches.sv
// Serial programming front end, config latches, reference divider and AXI4-Lite view.
//
// Design decisions made here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "psc_defines.svh"
module psc_config_latches
  import psc_pkg::*;
#(
  parameter int RCNT_W = 10
)(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Serial pins and other device pins, asynchronous to aclk.
  input wire psc_serial_t serial_pins,
  input wire logic reference_input,
  input wire logic chip_enable,
  input wire logic loop_locked,
  // Device outputs.
  output logic lock_indicator_pin,
  output logic monitor_output_pin,
  output logic monitor_output_oe,
  output logic power_down,
  output logic cp_three_state,
  output logic pfd_ref_pulse,
  output logic int_n_mode,
  output logic [1:0] abp_cycles,
  output logic [15:0] fb_int,
  output logic [11:0] fb_frac,
  output logic [11:0] fb_mod,
  output logic [11:0] fb_phase,
  output logic [3:0] cp_current,
  output logic [3:0] range_ok,
  // AXI4-Lite slave.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // The field positions of the reference ratio fix its width, so no other width can be served.
  if (RCNT_W != 10)
  begin : g_rcnt_check
    $error("reference counter must be 10 bits");
  end

  function automatic logic at_least(input logic [15:0] v, input logic [15:0] lo);
    at_least = v >= lo;
  endfunction

  // Pin synchronisers: stage a feeds only stage b; c is the edge history.
  logic [5:0] sy_a, sy_b;
  logic [2:0] sy_c;
  logic [31:0] shreg, next_shreg;
  logic [31:0] latch [`PSC_NUM_LATCH];
  logic [31:0] act1, act2, ctrl;
  logic [RCNT_W-1:0] rcnt, next_rcnt;
  logic half, next_half, pfd_level, next_pfd;
  logic sclk_rise, strobe_rise, ref_rise, ref_fall, ref_evt, commit;
  logic [2:0] sel;
  logic [RCNT_W-1:0] rdiv;

  assign sclk_rise = sy_b[0] & ~sy_c[0];
  assign strobe_rise = sy_b[2] & ~sy_c[2];
  assign ref_rise = sy_b[3] & ~sy_c[1];
  assign ref_fall = ~sy_b[3] & sy_c[1];
  assign sel = shreg[2:0];
  assign commit = strobe_rise && ctrl[0] && sel == `PSC_SEL_R0;
  assign rdiv = act2[`PSC_RCNT_HI:`PSC_RCNT_LO];

  always_ff @(posedge aclk) begin
    if (!aresetn)
    begin
      sy_a <= 6'h00;
      sy_b <= 6'h00;
      sy_c <= 3'h0;
    end
    else
    begin
      sy_a <= {loop_locked, chip_enable, reference_input, serial_pins.strobe,
               serial_pins.sdata, serial_pins.sclk};
      sy_b <= sy_a;
      sy_c <= {sy_b[2], sy_b[3], sy_b[0]};
    end
  end

  // Serial shift path.
  always_comb begin
    next_shreg = shreg;
    if (sclk_rise)
      next_shreg = {shreg[30:0], sy_b[1]};
  end

  // Latches are loaded only from the strobe, so a word half shifted never lands.
  always_ff @(posedge aclk) begin
    if (!aresetn)
    begin
      shreg <= 32'h00000000;
      act1 <= 32'h00000000;
      act2 <= 32'h00000000;
      for (int i = 0; i < `PSC_NUM_LATCH; i++)
        latch[i] <= 32'h00000000;
    end
    else
    begin
      shreg <= next_shreg;
      if (strobe_rise && ctrl[0] && sel <= `PSC_SEL_LAST)
        latch[sel] <= shreg;
      if (commit)
      begin
        act1 <= latch[1];
        act2 <= latch[2];
      end
    end
  end

  // Reference divider; a ratio of zero is served as one.
  always_comb begin
    ref_evt = ref_rise | (act2[`PSC_DBL_BIT] & ref_fall);
    next_rcnt = rcnt;
    next_half = half;
    next_pfd = 1'b0;
    if (ref_evt)
    begin
      if (rcnt + 1'b1 >= rdiv || rdiv == '0)
      begin
        next_rcnt = '0;
        next_half = ~half;
        next_pfd = ~act2[`PSC_RDIV2_BIT] | half;
      end
      else
        next_rcnt = rcnt + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
    begin
      rcnt <= '0;
      half <= 1'b0;
      pfd_ref_pulse <= 1'b0;
      pfd_level <= 1'b0;
    end
    else
    begin
      rcnt <= next_rcnt;
      half <= next_half;
      pfd_ref_pulse <= next_pfd;
      if (next_pfd)
        pfd_level <= ~pfd_level;
    end
  end

  // Active settings and status; register 0 itself has no buffering.
  logic [2:0] mon_sel;
  logic mon_q, mon_oe_q;
  always_ff @(posedge aclk) begin
    if (!aresetn)
    begin
      fb_int <= 16'h0000;
      fb_frac <= 12'h000;
      fb_mod <= 12'h000;
      fb_phase <= 12'h000;
      cp_current <= 4'h0;
      int_n_mode <= 1'b0;
      // Reset shows the default long width, so no illegal width is ever seen.
      abp_cycles <= 2'(`PSC_ABP_LONG_CYC);
      range_ok <= 4'h0;
      power_down <= 1'b1;
      cp_three_state <= 1'b1;
      lock_indicator_pin <= 1'b0;
      mon_q <= 1'b0;
      mon_oe_q <= 1'b0;
    end
    else
    begin
      fb_int <= latch[0][`PSC_INT_HI:`PSC_INT_LO];
      fb_frac <= latch[0][`PSC_FRAC_HI:`PSC_FRAC_LO];
      fb_mod <= act1[`PSC_FRAC_HI:`PSC_FRAC_LO];
      fb_phase <= act1[`PSC_PHASE_HI:`PSC_PHASE_LO];
      cp_current <= act2[`PSC_CP_HI:`PSC_CP_LO];
      int_n_mode <= fb_frac == 12'h000 && latch[2][`PSC_LDF_BIT];
      abp_cycles <= latch[3][`PSC_ABP_BIT] ? 2'(`PSC_ABP_SHORT_CYC)
                                         : 2'(`PSC_ABP_LONG_CYC);
      range_ok[0] <= latch[1][`PSC_PRESC_BIT] ? at_least(fb_int, `PSC_INT_MIN_89)
        : at_least(fb_int, `PSC_INT_MIN_45) && fb_int <= `PSC_INT_MAX_45;
      range_ok[1] <= fb_frac < fb_mod;
      range_ok[2] <= at_least({4'h0, fb_mod},
        {4'h0, latch[2][`PSC_NOISE_HI:`PSC_NOISE_LO] == `PSC_LOW_SPUR
               ? `PSC_MOD_MIN_LS : `PSC_MOD_MIN_LN});
      range_ok[3] <= rdiv != '0;
      power_down <= ~sy_b[4];
      cp_three_state <= ~sy_b[4] | latch[2][`PSC_TRI_BIT];
      lock_indicator_pin <= sy_b[5] & sy_b[4];
      mon_oe_q <= mon_sel != 3'h0;
      case (mon_sel)
        3'h1: mon_q <= 1'b1;
        3'h2: mon_q <= 1'b0;
        3'h4: mon_q <= pfd_level;
        3'h6: mon_q <= sy_b[5];
        default: mon_q <= 1'b0;
      endcase
    end
  end
  assign mon_sel = latch[2][`PSC_MON_HI:`PSC_MON_LO];
  assign monitor_output_pin = mon_q;
  assign monitor_output_oe = mon_oe_q;

  // AXI4-Lite write path: address and data taken in either order.
  psc_wstate_t wst, next_wst;
  logic aw_got, w_got, next_aw_got, next_w_got;
  logic [7:0] waddr, next_waddr;
  logic [31:0] wdata, next_wdata, next_ctrl;
  logic [1:0] next_bresp;
  // The strobe is kept with the data, since the master may change it once the data is taken.
  logic wstrb0, next_wstrb0;
  always_comb begin
    next_wst = wst;
    next_aw_got = aw_got;
    next_w_got = w_got;
    next_waddr = waddr;
    next_wdata = wdata;
    next_wstrb0 = wstrb0;
    next_ctrl = ctrl;
    next_bresp = s_axi_bresp;
    case (wst)
      PSC_WIDLE:
      begin
        if (s_axi_awvalid && s_axi_awready)
        begin
          next_aw_got = 1'b1;
          next_waddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
          next_w_got = 1'b1;
          next_wdata = s_axi_wdata;
          next_wstrb0 = s_axi_wstrb[0];
        end
        if (next_aw_got && next_w_got)
        begin
          next_wst = PSC_WRESP;
          next_bresp = next_waddr == `PSC_A_CTRL ? `PSC_RESP_OK : `PSC_RESP_ERR;
          if (next_waddr == `PSC_A_CTRL && next_wstrb0)
            next_ctrl = {31'h0, next_wdata[0]};
        end
      end
      PSC_WRESP:
        if (s_axi_bready)
        begin
          next_wst = PSC_WIDLE;
          next_aw_got = 1'b0;
          next_w_got = 1'b0;
        end
      default: next_wst = PSC_WIDLE;
    endcase
  end
  assign s_axi_awready = wst == PSC_WIDLE && !aw_got;
  assign s_axi_wready = wst == PSC_WIDLE && !w_got;
  assign s_axi_bvalid = wst == PSC_WRESP;

  always_ff @(posedge aclk) begin
    if (!aresetn)
    begin
      wst <= PSC_WIDLE;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      waddr <= 8'h00;
      wdata <= 32'h00000000;
      wstrb0 <= 1'b0;
      ctrl <= `PSC_CTRL_RST;
      s_axi_bresp <= `PSC_RESP_OK;
    end
    else
    begin
      wst <= next_wst;
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      waddr <= next_waddr;
      wdata <= next_wdata;
      wstrb0 <= next_wstrb0;
      ctrl <= next_ctrl;
      s_axi_bresp <= next_bresp;
    end
  end

  // AXI4-Lite read path: one cycle from address to data.
  logic [31:0] rd;
  logic rd_ok;
  always_comb begin
    rd = 32'h00000000;
    rd_ok = 1'b1;
    if (s_axi_araddr[7:2] < 6'(`PSC_NUM_LATCH) && s_axi_araddr[1:0] == 2'h0)
      rd = latch[s_axi_araddr[4:2]];
    else
      case (s_axi_araddr)
        `PSC_A_ACT1: rd = act1;
        `PSC_A_ACT2: rd = act2;
        `PSC_A_STAT: rd = {23'h0, int_n_mode, lock_indicator_pin, power_down,
                           range_ok, abp_cycles};
        `PSC_A_CTRL: rd = ctrl;
        default: rd_ok = 1'b0;
      endcase
  end
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `PSC_RESP_OK;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd;
      s_axi_rresp <= rd_ok ? `PSC_RESP_OK : `PSC_RESP_ERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Checks.
  property p_shift;
    @(posedge aclk) disable iff (!aresetn) sclk_rise |=> shreg[0] == $past(sy_b[1]);
  endproperty
  a_shift: assert property (p_shift) else $error("shift bit lost");
  property p_latch;
    @(posedge aclk) disable iff (!aresetn)
      strobe_rise && ctrl[0] && sel == 3'h3 |=> latch[3] == $past(shreg);
  endproperty
  a_latch: assert property (p_latch) else $error("latch not loaded");
  property p_bad_sel;
    @(posedge aclk) disable iff (!aresetn)
      strobe_rise && sel > 3'h5 |=> $stable(latch[0]) && $stable(latch[5]);
  endproperty
  a_bad_sel: assert property (p_bad_sel) else $error("bad select wrote");
  property p_hold;
    @(posedge aclk) disable iff (!aresetn) !commit |=> $stable(act1) && $stable(act2);
  endproperty
  a_hold: assert property (p_hold) else $error("buffer moved early");
  property p_commit;
    @(posedge aclk) disable iff (!aresetn)
      commit |=> act2 == $past(latch[2]) && latch[0] == $past(shreg);
  endproperty
  a_commit: assert property (p_commit) else $error("commit not applied");
  sequence s_clear;
    !sy_b[4] ##1 1'b1;
  endsequence
  property p_pd;
    @(posedge aclk) disable iff (!aresetn) s_clear |-> power_down && cp_three_state;
  endproperty
  a_pd: assert property (p_pd) else $error("not powered down");
  property p_intn;
    @(posedge aclk) disable iff (!aresetn)
      int_n_mode |-> $past(fb_frac) == 12'h000 && $past(latch[2][8]);
  endproperty
  a_intn: assert property (p_intn) else $error("bad integer mode");
  property p_abp;
    @(posedge aclk) disable iff (!aresetn) abp_cycles == 2'h1 || abp_cycles == 2'h2;
  endproperty
  a_abp: assert property (p_abp) else $error("bad pulse width");
  property p_rdiv;
    @(posedge aclk) disable iff (!aresetn) pfd_ref_pulse |-> $past(rcnt) + 1'b1 >= $past(rdiv)
      || $past(rdiv) == '0;
  endproperty
  a_rdiv: assert property (p_rdiv) else $error("early reference pulse");
endmodule // psc_config_latches

// ### bench/psc_serial_ctrl.sv
// Model of the controller that shifts programming words into the block.
`timescale 1ns/1ps
module psc_serial_ctrl
  import psc_pkg::*;
(
  // Clock.
  input wire logic aclk,
  // Serial pins toward the block.
  output psc_serial_t serial_pins
);
  initial serial_pins = '0;
  // Four cycles per level clear the two-flop synchroniser with margin.
  task automatic hold_lvl();
    repeat (4) @(posedge aclk);
  endtask
  task automatic send_word(input logic [31:0] w);
    for (int i = 31; i >= 0; i--)
    begin
      serial_pins.sdata <= w[i];
      hold_lvl();
      serial_pins.sclk <= 1'b1;
      hold_lvl();
      serial_pins.sclk <= 1'b0;
    end
    // The data line carries nothing after the word, so it is not left at its last value.
    serial_pins.sdata <= ~w[0];
    hold_lvl();
    serial_pins.strobe <= 1'b1;
    hold_lvl();
    serial_pins.strobe <= 1'b0;
    hold_lvl();
  endtask
endmodule // psc_serial_ctrl

// ### bench/test_pll_serial_config_latches.sv
// Self-checking testbench of the serial config latches and their register view.
`timescale 1ns/1ps
`include "psc_defines.svh"
`define CHK(g, e) \
  begin \
    cmp_count++; \
    if ((g) !== (e)) \
    begin \
      n_fail++; \
      $display("wrong value at %0t: got %h expected %h", $time, g, e); \
    end \
  end
module test_pll_serial_config_latches
  import psc_pkg::*;
();
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic reference_input = 1'b0;
  logic chip_enable = 1'b1;
  logic loop_locked = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  psc_serial_t serial_pins;
  logic lock_indicator_pin, monitor_output_pin, monitor_output_oe, power_down, cp_three_state;
  logic pfd_ref_pulse, int_n_mode, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] abp_cycles, s_axi_bresp, s_axi_rresp;
  logic [15:0] fb_int;
  logic [11:0] fb_frac, fb_mod, fb_phase;
  logic [3:0] cp_current, range_ok;
  logic [31:0] s_axi_rdata;
  int n_fail = 0;
  int cmp_count = 0;
  int pulses = 0;
  int toggles = 0;
  logic mon_prev = 1'b0;
  logic ref_tick = 1'b0;
  psc_config_latches u_psc_config_latches (.aclk, .aresetn, .serial_pins, .reference_input,
    .chip_enable, .loop_locked, .lock_indicator_pin, .monitor_output_pin, .monitor_output_oe,
    .power_down, .cp_three_state, .pfd_ref_pulse, .int_n_mode, .abp_cycles, .fb_int, .fb_frac,
    .fb_mod, .fb_phase, .cp_current, .range_ok, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  psc_serial_ctrl u_psc_serial_ctrl (.aclk, .serial_pins);
  initial
  begin
    forever #2.5 aclk = ~aclk;
  end
  // The reference pin toggles every second clock, a period of four clocks.
  always @(posedge aclk)
  begin
    ref_tick <= ~ref_tick;
    if (ref_tick)
      reference_input <= ~reference_input;
    if (pfd_ref_pulse === 1'b1)
      pulses <= pulses + 1;
    mon_prev <= monitor_output_pin;
    if (monitor_output_pin !== mon_prev)
      toggles <= toggles + 1;
  end
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic snd(input logic [31:0] w);
    u_psc_serial_ctrl.send_word(w);
  endtask
  function automatic logic [31:0] w0(input logic [15:0] i, input logic [11:0] f);
    return {1'b0, i, f, 3'h0};
  endfunction
  function automatic logic [31:0] w1(input logic p, input logic [11:0] ph, input logic [11:0] m);
    return {4'h0, p, ph, m, 3'h1};
  endfunction
  function automatic logic [31:0] w2(input logic [2:0] mon, input logic [1:0] dr,
    input logic [3:0] cp, input logic lock_detect_function_bit);
    return {3'h0, mon, dr, 10'h004, 1'b0, cp, lock_detect_function_bit, 5'h00, 3'h2};
  endfunction
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    `CHK(s_axi_rdata, e)
    `CHK(s_axi_rresp, er)
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic test_reset();
    rd_chk(8'h00, 32'h00000000, `PSC_RESP_OK);
    `CHK(power_down, 1'b0)
    `CHK(abp_cycles, 2'h2)
    rd_chk(8'h20, 32'h00000002, `PSC_RESP_OK);
    chip_enable <= 1'b0;
    wait_cyc(8);
    `CHK(power_down, 1'b1)
    `CHK(cp_three_state, 1'b1)
    chip_enable <= 1'b1;
  endtask
  task automatic test_latch0();
    snd(w0(16'h0064, 12'h005));
    `CHK(fb_int, 16'h0064)
    `CHK(fb_frac, 12'h005)
    rd_chk(8'h00, w0(16'h0064, 12'h005), `PSC_RESP_OK);
    `CHK(range_ok[1:0], 2'h1)
  endtask
  task automatic test_buffer();
    snd(w1(1'b0, 12'h001, 12'h0C8));
    `CHK(fb_mod, 12'h000)
    rd_chk(8'h04, w1(1'b0, 12'h001, 12'h0C8), `PSC_RESP_OK);
    rd_chk(8'h18, 32'h00000000, `PSC_RESP_OK);
    snd(w2(3'h0, 2'h0, 4'h5, 1'b0));
    `CHK(cp_current, 4'h0)
    snd(w0(16'h0016, 12'h000));
    `CHK({fb_mod, fb_phase, cp_current}, {12'h0C8, 12'h001, 4'h5})
    rd_chk(8'h1C, w2(3'h0, 2'h0, 4'h5, 1'b0), `PSC_RESP_OK);
    `CHK(range_ok, 4'hE)
    snd(w0(16'h0017, 12'h000));
    `CHK(range_ok[0], 1'b1)
    // Modulus 1 and the larger prescaler put both lower bounds on trial together.
    snd(w1(1'b1, 12'h001, 12'h001));
    snd(w0(16'h004A, 12'h000));
    `CHK(range_ok, 4'hA)
    snd(w0(16'h004B, 12'h000));
    `CHK(range_ok, 4'hB)
    // Low spur mode raises the lowest legal modulus; the mode bits act at once.
    snd(w1(1'b1, 12'h001, 12'h031));
    snd(w2(3'h0, 2'h0, 4'h5, 1'b0) | 32'h60000000);
    snd(w0(16'h004B, 12'h000));
    `CHK(range_ok, 4'hB)
    snd(w1(1'b1, 12'h001, 12'h032));
    snd(w0(16'h004B, 12'h000));
    `CHK(range_ok, 4'hF)
    snd(w2(3'h0, 2'h0, 4'h5, 1'b0));
    snd(w1(1'b1, 12'h001, 12'h0C8));
  endtask
  task automatic test_select();
    for (int k = 3; k < 8; k++)
      snd({13'h0000, 16'(k), 3'(k)});
    for (int k = 3; k < 6; k++)
      rd_chk(8'(4 * k), {13'h0000, 16'(k), 3'(k)}, `PSC_RESP_OK);
  endtask
  task automatic test_modes();
    snd(w2(3'h1, 2'h0, 4'h5, 1'b1));
    `CHK({monitor_output_pin, monitor_output_oe}, 2'h3)
    snd(w2(3'h2, 2'h0, 4'h5, 1'b1));
    `CHK({monitor_output_pin, monitor_output_oe}, 2'h1)
    snd(w0(16'h004B, 12'h000));
    `CHK(int_n_mode, 1'b1)
    snd(w0(16'h004B, 12'h003));
    `CHK(int_n_mode, 1'b0)
    snd({9'h000, 1'b1, 19'h00000, 3'h3});
    `CHK(abp_cycles, 2'h1)
    snd(w2(3'h6, 2'h0, 4'h5, 1'b1));
    loop_locked <= 1'b1;
    wait_cyc(8);
    `CHK({monitor_output_pin, lock_indicator_pin}, 2'h3)
    loop_locked <= 1'b0;
    wait_cyc(8);
    `CHK({monitor_output_pin, lock_indicator_pin}, 2'h0)
    snd(w2(3'h0, 2'h0, 4'h5, 1'b0));
    `CHK(monitor_output_oe, 1'b0)
  endtask
  task automatic test_refdiv();
    int exp_n[3] = '{50, 100, 25};
    int p0;
    int t0;
    for (int c = 0; c < 3; c++)
    begin
      snd(w2(3'h4, (c == 1) ? 2'h2 : ((c == 2) ? 2'h1 : 2'h0), 4'h5, 1'b0));
      snd(w0(16'h004B, 12'h000));
      p0 = pulses;
      t0 = toggles;
      wait_cyc(800);
      `CHK((pulses - p0) inside {[exp_n[c] - 1 : exp_n[c] + 1]}, 1'b1)
      `CHK((toggles - t0) inside {[exp_n[c] - 1 : exp_n[c] + 1]}, 1'b1)
    end
  endtask
  task automatic test_axi();
    logic [1:0] r;
    axi_wr(8'h24, 32'h00000000, r);
    `CHK(r, `PSC_RESP_OK)
    snd(w0(16'h1234, 12'h000));
    `CHK(fb_int, 16'h004B)
    axi_wr(8'h24, 32'h00000001, r);
    axi_wr(8'h00, 32'h00000000, r);
    `CHK(r, `PSC_RESP_ERR)
    rd_chk(8'h40, 32'h00000000, `PSC_RESP_ERR);
    rd_chk(8'h24, 32'h00000001, `PSC_RESP_OK);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    #200000;
    n_fail++;
    print_verdict();
  end
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    wait_cyc(8);
    test_reset();
    test_latch0();
    test_buffer();
    test_select();
    test_modes();
    test_refdiv();
    test_axi();
    print_verdict();
  end
endmodule // test_pll_serial_config_latches
